/* src/ccw_comparator_ctrl.sv */
// comparator control, pin and timer routing, wake flag and interrupt, apb slave
// Notes on behaviour
// - The top bit of the control register reads the comparator result, one when plus is above minus.
// - With the pin-disable bit clear the result drives the output pin, with it set it does not.
// - The polarity bit set passes the result, clear inverts it.
// - With the routing bit clear the result clocks the timer, otherwise the timer clock select decides.
// - The comparator-on bit powers the comparator.
// - The negative-select bit picks the negative pin when set, the internal reference when clear.
// - The positive-select bit picks the positive pin when set, the negative pin when clear.
// - The wake bit is active low: zero enables wake on a result change.
// - With the comparator off, its pin, polarity, routing, select and wake bits have no effect.
// - A result enabled onto the pin overrides the timer clock select's control of pin direction.
// - The wake flag sets only when wake is enabled, the register was read, the device sleeps and the result changed.
// - Software may clear the wake flag and any reset other than a comparator wake clears it.
// - A comparator left on when sleep starts keeps running during sleep.
// - Power-on reset loads every control bit with one.
// - The comparator is held powered down while any reset is asserted.
// - After a comparator wake reset the status bit six reads one, after any other reset zero.
`timescale 1ns/1ns
`default_nettype none

module ccw_comparator_ctrl
    import ccw_pkg::*;
(
    // clock and power-on reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic pready_out,
    output logic pslverr_out,
    output logic [31:0] prdata_out,
    // analog comparator
    input wire logic comparator_raw_in,
    output ccw_pkg::ccw_analog_s analog_out,
    // shared pin and timer clock mux
    input wire logic timer_pin_clk_in,
    input wire logic cycle_tick_in,
    input wire logic shared_pin_data_in,
    input wire logic direction_control_in,
    input wire logic timer_clock_select_in,
    output ccw_pkg::ccw_pins_s pins_out,
    // core status
    input wire logic sleep_in,
    input wire logic device_reset_in,
    input wire logic wake_reset_in,
    output logic compare_wake_flag_out,
    output logic irq_out
);
    import ccw_pkg::*;

    // ****************************************
    // state and decode
    // ****************************************
    ccw_state_s s;
    ccw_state_s next_s;

    logic access;
    logic done;
    logic wr;
    logic rd_ctrl;
    logic mapped;
    logic on;
    logic to_pin;
    logic to_timer;
    logic pol_result;
    logic wake_set;
    logic change_ev;
    logic [31:0] rd_word;

    // one wait state so that read data comes from a flop
    assign access = psel_in & penable_in & ~s.pready;
    assign done = psel_in & penable_in & s.pready;
    assign wr = done & pwrite_in;
    assign rd_ctrl = done & ~pwrite_in & (paddr_in == CCW_OFS_CTRL);
    assign mapped = (paddr_in == CCW_OFS_CTRL) | (paddr_in == CCW_OFS_WAKE)
        | (paddr_in == CCW_OFS_IRQ_STAT) | (paddr_in == CCW_OFS_IRQ_MASK);

    // ****************************************
    // comparator behaviour
    // ****************************************
    // control bits only count while the comparator is on
    assign on = s.ctrl[CCW_BIT_ON];
    assign to_pin = on & ~s.ctrl[CCW_BIT_PIN_DIS];
    assign to_timer = on & ~s.ctrl[CCW_BIT_ROUTE_N];
    assign pol_result = s.sync2 ^ ~s.ctrl[CCW_BIT_POL];
    assign change_ev = on & (s.sync2 != s.res_q);
    // latched value compared, so a change before sleep still wakes
    assign wake_set = on & ~s.ctrl[CCW_BIT_WAKE_N] & s.armed & sleep_in
        & (s.sync2 != s.latched);

    always_comb
    begin
        rd_word = 32'h0;
        case (paddr_in)
            CCW_OFS_CTRL:
            begin
                rd_word[7:0] = {s.sync2, s.ctrl};
            end
            CCW_OFS_WAKE:
            begin
                rd_word[CCW_BIT_WAKE_FLAG] = s.wake_flag;
            end
            CCW_OFS_IRQ_STAT:
            begin
                rd_word[1:0] = s.irq_stat;
            end
            CCW_OFS_IRQ_MASK:
            begin
                rd_word[1:0] = s.irq_mask;
            end
            default:
            begin
                rd_word = 32'h0;
            end
        endcase
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        next_s = s;
        // first flop feeds only the second
        next_s.sync1 = comparator_raw_in;
        next_s.sync2 = s.sync1;
        next_s.res_q = s.sync2;
        next_s.tsync1 = timer_pin_clk_in;
        next_s.tsync2 = s.tsync1;
        // bus answer
        next_s.pready = access;
        next_s.pslverr = access & ~mapped;
        next_s.prdata = access ? rd_word : 32'h0;
        if (wr && paddr_in == CCW_OFS_CTRL)
        begin
            next_s.ctrl = pwdata_in[6:0];
        end
        if (wr && paddr_in == CCW_OFS_IRQ_MASK)
        begin
            next_s.irq_mask = pwdata_in[1:0];
        end
        // reading the control register arms change detection
        if (rd_ctrl)
        begin
            next_s.armed = 1'b1;
            next_s.latched = s.sync2;
        end
        // write-one clear, a set in the same cycle wins
        if (wr && paddr_in == CCW_OFS_WAKE && pwdata_in[CCW_BIT_WAKE_FLAG])
        begin
            next_s.wake_flag = 1'b0;
        end
        if (wake_set)
        begin
            next_s.wake_flag = 1'b1;
        end
        if (wr && paddr_in == CCW_OFS_IRQ_STAT)
        begin
            next_s.irq_stat = s.irq_stat & ~pwdata_in[1:0];
        end
        next_s.irq_stat[CCW_IRQ_CHANGE] = next_s.irq_stat[CCW_IRQ_CHANGE] | change_ev;
        next_s.irq_stat[CCW_IRQ_WAKE] = next_s.irq_stat[CCW_IRQ_WAKE] | wake_set;
        next_s.irq = |(s.irq_stat & s.irq_mask);
        // sleep does not gate power
        next_s.analog.power = on & ~device_reset_in;
        next_s.analog.minus_sel = on & s.ctrl[CCW_BIT_NEG_SEL];
        next_s.analog.plus_sel = on & s.ctrl[CCW_BIT_POS_SEL];
        next_s.pins.pin_value = to_pin ? pol_result : shared_pin_data_in;
        // driving the result beats the timer clock input on direction
        next_s.pins.pin_oe = to_pin | ~(direction_control_in | timer_clock_select_in);
        if (to_timer)
        begin
            next_s.pins.timer_clk = pol_result;
        end
        else
        begin
            next_s.pins.timer_clk = timer_clock_select_in ? s.tsync2 : cycle_tick_in;
        end
        // warm reset keeps control, wake flag survives only its own reset
        if (device_reset_in)
        begin
            next_s.armed = 1'b0;
            next_s.wake_flag = wake_reset_in & s.wake_flag;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            s <= '0;
            s.ctrl <= CCW_CTRL_RST;
            s.irq_stat <= CCW_IRQ_RST;
            s.irq_mask <= CCW_IRQ_RST;
        end
        else
        begin
            s <= next_s;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign pready_out = s.pready;
    assign pslverr_out = s.pslverr;
    assign prdata_out = s.prdata;
    assign analog_out = s.analog;
    assign pins_out = s.pins;
    assign compare_wake_flag_out = s.wake_flag;
    assign irq_out = s.irq;

    // ****************************************
    // checks
    // ****************************************
    AST_RESULT_READ: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (access && !pwrite_in && paddr_in == CCW_OFS_CTRL)
        |=> prdata_out[CCW_BIT_RESULT] == $past(s.sync2))
        else $error("result bit does not match synchronised comparator");

    AST_PIN_DRIVE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        to_pin |=> pins_out.pin_oe && pins_out.pin_value == $past(pol_result))
        else $error("result not driven onto the pin");

    AST_POLARITY: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (to_pin && s.ctrl[CCW_BIT_POL] == 1'b0)
        |=> pins_out.pin_value == !$past(s.sync2))
        else $error("inverted polarity not applied");

    AST_TIMER_ROUTE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (!to_timer && !timer_clock_select_in)
        |=> pins_out.timer_clk == $past(cycle_tick_in))
        else $error("timer clock not from its own select");

    AST_POWER: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        device_reset_in |=> !analog_out.power)
        else $error("comparator powered during reset");

    AST_OFF_IGNORE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (!on && direction_control_in)
        |=> !pins_out.pin_oe && !analog_out.plus_sel && !analog_out.minus_sel)
        else $error("control bits acted while comparator off");

    AST_WAKE_SET: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        $rose(compare_wake_flag_out)
        |-> $past(sleep_in) && $past(s.armed) && !$past(s.ctrl[CCW_BIT_WAKE_N]))
        else $error("wake flag set without its conditions");

    AST_WAKE_CLEAR: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (device_reset_in && !wake_reset_in) |=> !compare_wake_flag_out)
        else $error("wake flag survived a non-wake reset");

    AST_RESET_CTRL: assert property (@(posedge clk_sys_in)
        rst_in |=> s.ctrl == CCW_CTRL_RST && !analog_out.power)
        else $error("control register not all ones after power-on reset");

    AST_SYNC: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        ##2 s.sync2 == $past(comparator_raw_in, 2))
        else $error("synchroniser depth wrong");

    // ****************************************
    // checks on power, selects, pins and wake
    // ****************************************
    AST_POWER_OFF: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !on
        |=> !analog_out.power)
        else $error("comparator powered while switched off");

    // sleep alone never gates power, only the on bit and a reset do
    AST_SLEEP_POWER: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (on && sleep_in && !device_reset_in)
        |=> analog_out.power)
        else $error("comparator stopped during sleep");

    AST_MINUS_SEL: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        on
        |=> analog_out.minus_sel == $past(s.ctrl[CCW_BIT_NEG_SEL]))
        else $error("minus input select wrong");

    AST_PLUS_SEL: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        on
        |=> analog_out.plus_sel == $past(s.ctrl[CCW_BIT_POS_SEL]))
        else $error("plus input select wrong");

    // the flag may be kept but never raised while wake is off
    AST_WAKE_DISABLED: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (s.ctrl[CCW_BIT_WAKE_N] && !compare_wake_flag_out) |=> !compare_wake_flag_out)
        else $error("wake flag set while wake disabled");

    AST_PIN_OFF: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (on && s.ctrl[CCW_BIT_PIN_DIS] && direction_control_in)
        |=> !pins_out.pin_oe)
        else $error("result driven onto a disabled pin");

    // timer pin clock would make the pin an input, the result wins
    AST_PIN_OVERRIDE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (to_pin && direction_control_in && timer_clock_select_in) |=> pins_out.pin_oe)
        else $error("timer select took the pin from the result");

    AST_POL_PASS: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (to_pin && s.ctrl[CCW_BIT_POL])
        |=> pins_out.pin_value == $past(s.sync2))
        else $error("true polarity not applied");

    AST_TIMER_RESULT: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        to_timer
        |=> pins_out.timer_clk == $past(pol_result))
        else $error("result not routed to the timer clock");

    AST_OFF_TIMER: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (!on && !timer_clock_select_in)
        |=> pins_out.timer_clk == $past(cycle_tick_in))
        else $error("routing bit acted while comparator off");

    AST_ARM: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (rd_ctrl && !device_reset_in)
        |=> s.armed && s.latched == $past(s.sync2))
        else $error("control read did not latch the result");

    // conditions spelled out, not taken from the wake_set term
    AST_WAKE_FWD: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (on && !s.ctrl[CCW_BIT_WAKE_N] && s.armed && sleep_in
        && s.sync2 != s.latched && !device_reset_in) |=> compare_wake_flag_out)
        else $error("wake flag missed a change in sleep");

    // a same-cycle set would win, so sleep is excluded here
    AST_SW_CLEAR: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (wr && paddr_in == CCW_OFS_WAKE && pwdata_in[CCW_BIT_WAKE_FLAG]
        && !sleep_in && !device_reset_in) |=> !compare_wake_flag_out)
        else $error("software clear of wake flag ignored");

    AST_WAKE_READ: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (access && !pwrite_in && paddr_in == CCW_OFS_WAKE)
        |=> prdata_out[CCW_BIT_WAKE_FLAG] == $past(compare_wake_flag_out))
        else $error("wake status bit reads wrong");

endmodule : ccw_comparator_ctrl

`default_nettype wire

/* src/ccw_pkg.sv */
// package: offsets, fields, reset values and carriers for the comparator control block
package ccw_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] CCW_OFS_CTRL = 8'h00;
    localparam logic [7:0] CCW_OFS_WAKE = 8'h04;
    localparam logic [7:0] CCW_OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] CCW_OFS_IRQ_MASK = 8'h0c;

    // ****************************************
    // comparator_control fields
    // ****************************************
    localparam int CCW_BIT_RESULT = 7;
    localparam int CCW_BIT_PIN_DIS = 6;
    localparam int CCW_BIT_POL = 5;
    localparam int CCW_BIT_ROUTE_N = 4;
    localparam int CCW_BIT_ON = 3;
    localparam int CCW_BIT_NEG_SEL = 2;
    localparam int CCW_BIT_POS_SEL = 1;
    localparam int CCW_BIT_WAKE_N = 0;
    localparam logic [6:0] CCW_CTRL_RST = 7'h7f;

    // ****************************************
    // other fields and reset values
    // ****************************************
    localparam int CCW_BIT_WAKE_FLAG = 6;
    localparam int CCW_IRQ_CHANGE = 0;
    localparam int CCW_IRQ_WAKE = 1;
    localparam logic [1:0] CCW_IRQ_RST = 2'h0;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic power;
        logic plus_sel;
        logic minus_sel;
    } ccw_analog_s;

    typedef struct packed {
        logic pin_value;
        logic pin_oe;
        logic timer_clk;
    } ccw_pins_s;

    typedef struct packed {
        logic [6:0] ctrl;
        logic sync1;
        logic sync2;
        logic res_q;
        logic tsync1;
        logic tsync2;
        logic latched;
        logic armed;
        logic wake_flag;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        ccw_analog_s analog;
        ccw_pins_s pins;
    } ccw_state_s;

endpackage : ccw_pkg

/* tb/ccw_analog_model.sv */
// behavioural analog comparator on the far side of the control block
`timescale 1ns/1ns
`default_nettype none
module ccw_analog_model
    import ccw_pkg::*;
#(
    parameter logic [7:0] VREF = 8'h80
)
(
    // selects and power from the block
    input wire ccw_pkg::ccw_analog_s analog_in,
    // pin levels
    input wire logic [7:0] pos_level_in,
    input wire logic [7:0] neg_level_in,
    // result
    output logic raw_out
);
    logic [7:0] plus_lvl;
    logic [7:0] minus_lvl;
    always_comb
    begin
        plus_lvl = analog_in.plus_sel ? pos_level_in : neg_level_in;
        minus_lvl = analog_in.minus_sel ? neg_level_in : VREF;
        // unpowered stage sits low, never a stale result
        raw_out = analog_in.power && (plus_lvl > minus_lvl);
    end
endmodule : ccw_analog_model
`default_nettype wire

/* tb/test_ccw_comparator_ctrl.sv */
// self-checking bench for the comparator control block
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module test_ccw_comparator_ctrl;
    import ccw_pkg::*;
    typedef struct packed {
        logic [6:0] ctrl;
        logic [7:0] pos;
        logic [7:0] neg;
        logic tick;
        logic [2:0] pins;
        logic [2:0] mask;
        logic [2:0] ana;
        logic [7:0] rd;
    } ccw_row_s;
    ccw_row_s rows [6] = '{
        '{7'h29, 8'h10, 8'hc0, 1'b0, 3'b111, 3'b111, 3'b100, 8'ha9},
        '{7'h09, 8'h10, 8'hc0, 1'b0, 3'b010, 3'b111, 3'b100, 8'h89},
        '{7'h0f, 8'h10, 8'hc0, 1'b0, 3'b111, 3'b111, 3'b111, 8'h0f},
        '{7'h7b, 8'hf0, 8'h10, 1'b1, 3'b001, 3'b011, 3'b110, 8'hfb},
        '{7'h7f, 8'h10, 8'hc0, 1'b0, 3'b000, 3'b011, 3'b111, 8'h7f},
        '{7'h77, 8'hf0, 8'h10, 1'b1, 3'b001, 3'b011, 3'b000, 8'h77}};
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, raw, tick = 0;
    logic sleep = 0, dev_rst = 0, wake_rst = 0, pready, pslverr, flag, irq, er;
    logic tcs = 0, tpin = 0;
    logic [7:0] paddr = 8'h00, pos = 8'h10, neg = 8'hc0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    ccw_analog_s ana;
    ccw_pins_s pins;
    int failures = 0, cmp_count = 0;
    always #5 clk = ~clk;
    ccw_analog_model model (.analog_in(ana), .pos_level_in(pos), .neg_level_in(neg),
        .raw_out(raw));
    ccw_comparator_ctrl dut (.clk_sys_in(clk), .rst_in(rst), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .pready_out(pready), .pslverr_out(pslverr), .prdata_out(prdata),
        .comparator_raw_in(raw), .analog_out(ana), .timer_pin_clk_in(tpin),
        .cycle_tick_in(tick), .shared_pin_data_in(1'b0), .direction_control_in(1'b1),
        .timer_clock_select_in(tcs), .pins_out(pins), .sleep_in(sleep),
        .device_reset_in(dev_rst), .wake_reset_in(wake_rst),
        .compare_wake_flag_out(flag), .irq_out(irq));
    // ****************************************
    // bus and ending tasks
    // ****************************************
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // no cycle count assumed, the watchdog covers a dead slave
        while (pready !== 1'b1)
        begin
            @(posedge clk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge so a following call never re-raises psel in this step
        @(posedge clk);
    endtask : apb
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report
    initial
    begin
        #100000;
        failures++;
        final_report();
    end
    // ****************************************
    // tests
    // ****************************************
    initial
    begin
        repeat (5) @(posedge clk);
        `CHK(ana.power, 1'b0)
        rst <= 1'b0;
        @(posedge clk);
        apb(1'b0, CCW_OFS_CTRL, 32'h0);
        `CHK(rd, 32'h7f)
        foreach (rows[i])
        begin
            apb(1'b1, CCW_OFS_CTRL, {25'h0, rows[i].ctrl});
            pos <= rows[i].pos;
            neg <= rows[i].neg;
            tick <= rows[i].tick;
            repeat (6) @(posedge clk);
            `CHK(pins & rows[i].mask, rows[i].pins)
            `CHK(ana, rows[i].ana)
            apb(1'b0, CCW_OFS_CTRL, 32'h0);
            `CHK(rd, {24'h0, rows[i].rd})
        end
        apb(1'b1, CCW_OFS_CTRL, 32'h28);
        dev_rst <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK(ana.power, 1'b0)
        dev_rst <= 1'b0;
        neg <= 8'h00;
        sleep <= 1'b1;
        repeat (4) @(posedge clk);
        neg <= 8'hff;
        repeat (6) @(posedge clk);
        `CHK(flag, 1'b0)
        sleep <= 1'b0;
        neg <= 8'h00;
        repeat (6) @(posedge clk);
        apb(1'b0, CCW_OFS_CTRL, 32'h0);
        sleep <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK(flag, 1'b0)
        `CHK(ana.power, 1'b1)
        neg <= 8'hff;
        repeat (6) @(posedge clk);
        `CHK(flag, 1'b1)
        `CHK(irq, 1'b0)
        apb(1'b1, CCW_OFS_IRQ_MASK, 32'h2);
        repeat (3) @(posedge clk);
        `CHK(irq, 1'b1)
        sleep <= 1'b0;
        dev_rst <= 1'b1;
        wake_rst <= 1'b1;
        repeat (2) @(posedge clk);
        dev_rst <= 1'b0;
        wake_rst <= 1'b0;
        apb(1'b0, CCW_OFS_WAKE, 32'h0);
        `CHK(rd, 32'h40)
        apb(1'b1, CCW_OFS_WAKE, 32'h40);
        repeat (2) @(posedge clk);
        `CHK(flag, 1'b0)
        apb(1'b1, CCW_OFS_IRQ_STAT, 32'h3);
        repeat (3) @(posedge clk);
        `CHK(irq, 1'b0)
        tcs <= 1'b1;
        tpin <= 1'b1;
        tick <= 1'b0;
        apb(1'b1, CCW_OFS_CTRL, 32'h39);
        repeat (6) @(posedge clk);
        `CHK(pins, 3'b111)
        apb(1'b1, CCW_OFS_CTRL, 32'h79);
        repeat (6) @(posedge clk);
        `CHK(pins, 3'b001)
        apb(1'b0, 8'h10, 32'h0);
        `CHK({er, rd}, {1'b1, 32'h0})
        final_report();
    end
endmodule : test_ccw_comparator_ctrl
`default_nettype wire
